// *** src/pifb_flag_reg.sv ***
module pifb_flag_reg
	import pifb_pkg::*;
#(
	parameter logic [7:0] IMPL = 8'hFF,
	parameter logic [7:0] LEVEL = 8'h00
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] set,
	input wire logic [7:0] level,
	input wire logic we,
	input wire logic [7:0] wdata,
	output logic [7:0] q
);
	logic [7:0] next_q;

	// Sticky bits: hardware set ORed after the write, so a set wins
	assign next_q = IMPL & ((LEVEL & level) | (~LEVEL & (set | (we ? wdata : q))));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= FLAG_RESET;
		end else begin
			q <= next_q;
		end
	end
endmodule

// *** src/pifb_pkg.sv ***
package pifb_pkg;

	// Bus geometry
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_FLAGS1 = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAGS2 = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS3 = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_FLAGS4 = 6'h0C;
	localparam logic [ADDR_W-1:0] OFS_FLAGS5 = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_ENABLES1 = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_CAPCMP_MODE = 6'h1C;

	// Implemented and hardware-followed bits per register
	localparam logic [7:0] IMPL_FLAGS1 = 8'h7F;
	localparam logic [7:0] IMPL_FULL = 8'hFF;
	localparam logic [7:0] IMPL_LOW3 = 8'h07;
	localparam logic [7:0] LEVEL_FLAGS1 = 8'h30;
	localparam logic [7:0] LEVEL_FLAGS3 = 8'h30;
	localparam logic [7:0] LEVEL_NONE = 8'h00;
	localparam logic [7:0] FLAG_RESET = 8'h00;

	// Control register fields
	localparam int CTRL_VOLT_DIR = 0;
	localparam int CTRL_PRIO_MODE = 1;
	localparam int CTRL_PERIPH_EN = 6;
	localparam int CTRL_GLOBAL_EN = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Capture/compare unit modes, two bits per unit
	localparam int CAPCMP_UNITS = 5;
	localparam logic [1:0] MODE_CAPTURE = 2'b00;
	localparam logic [1:0] MODE_COMPARE = 2'b01;
	localparam logic [1:0] MODE_PWM = 2'b10;
	localparam logic [9:0] CAPCMP_MODE_RESET = 10'h3FF;

	// One-cycle event pulses from peripherals on the core clock
	typedef struct packed {
		logic conv_done;
		logic sync1_done;
		logic timer2_match;
		logic timer1_ovf;
		logic osc_fail;
		logic mem_write;
		logic sync1_collision;
		logic timer3_ovf;
		logic sync2_done;
		logic sync2_collision;
		logic charge_meas;
		logic timer5_gate;
		logic timer3_gate;
		logic timer1_gate;
		logic timer6_match;
		logic timer5_ovf;
		logic timer4_match;
		logic [CAPCMP_UNITS-1:0] capture;
		logic [CAPCMP_UNITS-1:0] compare;
	} pifb_events_t;

	// Buffer state levels from the serial ports, core clock
	typedef struct packed {
		logic ser1_rx_full;
		logic ser1_tx_empty;
		logic ser2_rx_full;
		logic ser2_tx_empty;
	} pifb_levels_t;

	// Analog outputs, asynchronous to the core clock
	typedef struct packed {
		logic comp1_out;
		logic comp2_out;
		logic volt_above;
	} pifb_async_t;

	typedef struct packed {
		logic [7:0] one;
		logic [7:0] two;
		logic [7:0] three;
		logic [7:0] four;
		logic [7:0] five;
	} pifb_flags_t;

endpackage

// *** src/pifb_sync2.sv ***
module pifb_sync2 #(
	parameter int W = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	// Two stages; only the second stage is seen by any logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// *** src/pifb_top.sv ***
// Notes on behaviour
// - Flags set regardless of any enable bit
// - Unimplemented bits read zero, ignore writes
// - Converter done flag sticky until software clears
// - Serial one receive flag follows buffer full
// - Serial one transmit flag follows buffer empty
// - Sync port one done flag sticky
// - Capcmp one/two flags by mode, unused PWM
// - Capcmp three to five flags by mode
// - Timer2 period match flag sticky
// - Timer1 overflow flag sticky
// - Oscillator fail flag sticky
// - Comparator flags set on output change
// - Memory write complete flag sticky
// - Sync port one collision flag sticky
// - Voltage flag sets per direction select
// - Timer3 overflow flag sticky
// - Sync port two done and collision flags
// - Serial two flags follow buffer levels
// - Charge and timer gate flags sticky
// - Timer6, timer5, timer4 flags sticky
// - Enable one bits match flags, reset zero
// - Peripheral enable needed when priority mode off
// - Global enable gates the core interrupt, not the request, when priority off
module pifb_top
	import pifb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [pifb_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [pifb_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [pifb_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [pifb_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	input wire pifb_pkg::pifb_events_t events,
	input wire pifb_pkg::pifb_levels_t levels,
	input wire pifb_pkg::pifb_async_t analog,
	output pifb_pkg::pifb_flags_t flags,
	output logic [7:0] enables_one,
	output logic periph_req,
	output logic core_irq
);
	import pifb_pkg::*;

	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic [7:0] ctrl;
	logic [9:0] capcmp_mode;
	pifb_async_t analog_sync;
	pifb_async_t analog_prev;
	logic analog_valid;
	logic [1:0] warm_up;
	logic [9:0] wdata_mode;

	// Write channel: each half taken once, response after both
	wire do_write = !awready && !wready && !bvalid;
	wire wr_hit = (wr_addr == OFS_FLAGS1) || (wr_addr == OFS_FLAGS2) ||
		(wr_addr == OFS_FLAGS3) || (wr_addr == OFS_FLAGS4) ||
		(wr_addr == OFS_FLAGS5) || (wr_addr == OFS_ENABLES1) ||
		(wr_addr == OFS_CTRL) || (wr_addr == OFS_CAPCMP_MODE);
	wire wr_en = do_write && wr_lane;
	wire we_flags1 = wr_en && (wr_addr == OFS_FLAGS1);
	wire we_flags2 = wr_en && (wr_addr == OFS_FLAGS2);
	wire we_flags3 = wr_en && (wr_addr == OFS_FLAGS3);
	wire we_flags4 = wr_en && (wr_addr == OFS_FLAGS4);
	wire we_flags5 = wr_en && (wr_addr == OFS_FLAGS5);
	wire we_en1 = wr_en && (wr_addr == OFS_ENABLES1);
	wire we_ctrl = wr_en && (wr_addr == OFS_CTRL);
	wire we_mode = do_write && (wr_addr == OFS_CAPCMP_MODE);

	// Address and data held until the response is accepted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			wr_addr <= '0;
			wr_byte <= 8'h00;
			wr_lane <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wr_byte <= wdata[7:0];
				wr_lane <= wstrb[0];
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Comparator and voltage outputs are analog, so resynchronise first
	pifb_sync2 #(
		.W(3)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(analog),
		.sync_out(analog_sync)
	);

	// Edge history; held off until both sync stages and the history carry pin values,
	// since their reset zeros would fake an edge on a pin that idles high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_prev <= '0;
			warm_up <= 2'b00;
			analog_valid <= 1'b0;
		end else begin
			analog_prev <= analog_sync;
			warm_up <= {warm_up[0], 1'b1};
			analog_valid <= warm_up[1];
		end
	end

	wire comp1_chg = analog_valid && (analog_sync.comp1_out != analog_prev.comp1_out);
	wire comp2_chg = analog_valid && (analog_sync.comp2_out != analog_prev.comp2_out);
	wire volt_rise = analog_valid && analog_sync.volt_above && !analog_prev.volt_above;
	wire volt_fall = analog_valid && !analog_sync.volt_above && analog_prev.volt_above;
	wire volt_trip = ctrl[CTRL_VOLT_DIR] ? volt_rise : volt_fall;

	// Capture/compare sets gated by unit mode; PWM mode raises nothing
	logic [CAPCMP_UNITS-1:0] capcmp_set;
	genvar gi;
	generate
		for (gi = 0; gi < CAPCMP_UNITS; gi++) begin : g_capcmp
			wire [1:0] unit_mode = capcmp_mode[2*gi+1:2*gi];
			assign capcmp_set[gi] =
				((unit_mode == MODE_CAPTURE) && events.capture[gi]) ||
				((unit_mode == MODE_COMPARE) && events.compare[gi]);
		end
	endgenerate

	// Set vectors per register, independent of any enable
	wire [7:0] set_one = {1'b0, events.conv_done, 2'b00, events.sync1_done,
		capcmp_set[0], events.timer2_match, events.timer1_ovf};
	wire [7:0] set_two = {events.osc_fail, comp1_chg, comp2_chg, events.mem_write,
		events.sync1_collision, volt_trip, events.timer3_ovf,
		capcmp_set[1]};
	wire [7:0] set_three = {events.sync2_done, events.sync2_collision, 2'b00,
		events.charge_meas, events.timer5_gate, events.timer3_gate,
		events.timer1_gate};
	wire [7:0] set_four = {5'b00000, capcmp_set[4], capcmp_set[3], capcmp_set[2]};
	wire [7:0] set_five = {5'b00000, events.timer6_match, events.timer5_ovf,
		events.timer4_match};
	wire [7:0] lvl_one = {2'b00, levels.ser1_rx_full, levels.ser1_tx_empty, 4'h0};
	wire [7:0] lvl_three = {2'b00, levels.ser2_rx_full, levels.ser2_tx_empty, 4'h0};

	// One flag bank per register; unimplemented bits masked to zero
	pifb_flag_reg #(
		.IMPL(IMPL_FLAGS1),
		.LEVEL(LEVEL_FLAGS1)
	) u_flags1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(set_one),
		.level(lvl_one),
		.we(we_flags1),
		.wdata(wr_byte),
		.q(flags.one)
	);

	pifb_flag_reg #(
		.IMPL(IMPL_FULL),
		.LEVEL(LEVEL_NONE)
	) u_flags2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(set_two),
		.level(8'h00),
		.we(we_flags2),
		.wdata(wr_byte),
		.q(flags.two)
	);

	pifb_flag_reg #(
		.IMPL(IMPL_FULL),
		.LEVEL(LEVEL_FLAGS3)
	) u_flags3 (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(set_three),
		.level(lvl_three),
		.we(we_flags3),
		.wdata(wr_byte),
		.q(flags.three)
	);

	pifb_flag_reg #(
		.IMPL(IMPL_LOW3),
		.LEVEL(LEVEL_NONE)
	) u_flags4 (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(set_four),
		.level(8'h00),
		.we(we_flags4),
		.wdata(wr_byte),
		.q(flags.four)
	);

	pifb_flag_reg #(
		.IMPL(IMPL_LOW3),
		.LEVEL(LEVEL_NONE)
	) u_flags5 (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(set_five),
		.level(8'h00),
		.we(we_flags5),
		.wdata(wr_byte),
		.q(flags.five)
	);

	// Enables and control; mode needs both lanes, so uses the full word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enables_one <= FLAG_RESET;
			ctrl <= CTRL_RESET;
			capcmp_mode <= CAPCMP_MODE_RESET;
		end else begin
			if (we_en1) begin
				enables_one <= wr_byte & IMPL_FLAGS1;
			end
			if (we_ctrl) begin
				ctrl <= wr_byte;
			end
			if (we_mode) begin
				capcmp_mode <= wdata_mode;
			end
		end
	end

	// Mode word latched at the data handshake; wr_byte keeps only lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdata_mode <= CAPCMP_MODE_RESET;
		end else if (wvalid && wready) begin
			wdata_mode <= wdata[9:0];
		end
	end

	// Request and gated interrupt, both registered
	wire any_enabled = |(flags.one & enables_one);
	wire prio_on = ctrl[CTRL_PRIO_MODE];
	wire gate_open = prio_on ? (ctrl[CTRL_GLOBAL_EN] || ctrl[CTRL_PERIPH_EN]) :
		(ctrl[CTRL_GLOBAL_EN] && ctrl[CTRL_PERIPH_EN]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			periph_req <= 1'b0;
			core_irq <= 1'b0;
		end else begin
			periph_req <= any_enabled;
			core_irq <= any_enabled && gate_open;
		end
	end

	// Read decode; unmapped addresses answer SLVERR with zero data
	wire [7:0] rd_byte =
		(araddr == OFS_FLAGS1) ? flags.one :
		(araddr == OFS_FLAGS2) ? flags.two :
		(araddr == OFS_FLAGS3) ? flags.three :
		(araddr == OFS_FLAGS4) ? flags.four :
		(araddr == OFS_FLAGS5) ? flags.five :
		(araddr == OFS_ENABLES1) ? enables_one :
		(araddr == OFS_CTRL) ? ctrl : 8'h00;
	wire rd_hit = (araddr <= OFS_CAPCMP_MODE) && (araddr[1:0] == 2'b00);
	wire [DATA_W-1:0] rd_word = (araddr == OFS_CAPCMP_MODE) ?
		{22'h00_0000, capcmp_mode} : {24'h00_0000, rd_byte};

	// Read channel; buffer reads belong to the serial ports, no side effect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_conv_evt;
		events.conv_done;
	endsequence
	sequence s_clear_one;
		we_flags1 && !wr_byte[6];
	endsequence

	a_conv_set_wins: assert property (s_conv_evt and s_clear_one |=> flags.one[6])
		else $error("conversion flag lost against a clear");
	a_flag_poll: assert property (events.timer1_ovf && enables_one[0] == 1'b0 |=> flags.one[0])
		else $error("flag not set while disabled");
	a_unimpl_zero: assert property (!flags.one[7] && flags.four[7:3] == 5'h00
		&& flags.five[7:3] == 5'h00 && !enables_one[7])
		else $error("unimplemented bit set");
	a_rx_follow: assert property ($past(aresetn) |->
		flags.one[5] == $past(levels.ser1_rx_full)
		&& flags.one[4] == $past(levels.ser1_tx_empty))
		else $error("serial one flags do not follow buffer");
	a_ser2_follow: assert property (##1 flags.three[5:4] ==
		$past({levels.ser2_rx_full, levels.ser2_tx_empty}))
		else $error("serial two flags do not follow buffer");
	a_pwm_silent: assert property (capcmp_mode[1:0] == MODE_PWM && !flags.one[2]
		&& !(we_flags1 && wr_byte[2]) |=> !flags.one[2])
		else $error("capture flag set in PWM mode");
	a_comp_change: assert property (analog_valid && $changed(analog_sync.comp1_out)
		|=> flags.two[6])
		else $error("comparator change missed");
	a_req_form: assert property (##1 periph_req == $past(|(flags.one & enables_one)))
		else $error("request not OR of enabled flags");
	a_periph_gate: assert property (!prio_on && !ctrl[CTRL_PERIPH_EN] |=> !core_irq)
		else $error("interrupt without peripheral enable");
	a_global_gate: assert property (!prio_on && !ctrl[CTRL_GLOBAL_EN] |=> !core_irq)
		else $error("interrupt without global enable");
	a_en_reset: assert property ($rose(aresetn) |-> enables_one == 8'h00)
		else $error("enables not zero after reset");
endmodule

// *** verif/pifb_periph_model.sv ***
// Stand-in for the peripherals around the flag bank: event pulses, buffer levels, analog pins
module pifb_periph_model (
	input wire logic aclk,
	output pifb_pkg::pifb_events_t events,
	output pifb_pkg::pifb_levels_t levels,
	output pifb_pkg::pifb_async_t analog
);
	timeunit 1ns;
	timeprecision 1ps;
	import pifb_pkg::*;

	// Quiet peripherals at power-up
	initial begin
		events = '0;
		levels = '0;
		analog = '0;
	end

	// One-cycle pulse per event, called just after a clock edge
	task automatic fire(input pifb_events_t e);
		events <= e;
		@(posedge aclk);
		events <= '0;
	endtask

	// Buffer fill and drain as the serial ports see it
	task automatic set_level(input pifb_levels_t l);
		levels <= l;
	endtask

	// Comparator and detector pins, free of the core clock
	task automatic set_analog(input pifb_async_t a);
		analog <= a;
	endtask
endmodule

// *** verif/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pifb_pkg::*;

	logic aclk = 0;
	logic aresetn = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, rd;
	logic awready, wready, bvalid, arready, rvalid, periph_req, core_irq;
	logic [1:0] bresp, rresp, rs, ws;
	logic [3:0] wstrb = 4'hF;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [7:0] enables_one;
	pifb_events_t events, e;
	pifb_levels_t levels;
	pifb_async_t analog, a;
	pifb_flags_t flags;
	logic [ADDR_W-1:0] regs [6] = '{OFS_FLAGS1, OFS_FLAGS2, OFS_FLAGS3, OFS_FLAGS4,
		OFS_FLAGS5, OFS_ENABLES1};
	int num_errors = 0;
	int n_checks = 0;

	always #2.5 aclk = ~aclk;

	pifb_periph_model periph (.aclk, .events, .levels, .analog);

	pifb_top dut (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.arprot, .rvalid, .rready, .rdata, .rresp, .events, .levels, .analog,
		.flags, .enables_one, .periph_req, .core_irq
	);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Bound on every handshake wait; a stuck bus ends the run
	task automatic timeout_if(input int n);
		if (n >= 50) begin
			num_errors++;
			tally_and_finish();
		end
	endtask

	// Write with an optional event landing in the cycle the store happens
	task automatic wr_ev(input logic [5:0] ad, input logic [31:0] d, input pifb_events_t ev);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			n++;
		end while ((awvalid && !awready || wvalid && !wready) && n < 50);
		timeout_if(n);
		if (ev !== '0) fork
			periph.fire(ev);
		join_none
		do begin
			@(posedge aclk);
			n++;
		end while (!bvalid && n < 50);
		timeout_if(n);
		ws = bresp;
		bready <= 0;
	endtask

	task automatic wr(input logic [5:0] ad, input logic [31:0] d);
		wr_ev(ad, d, '0);
	endtask

	// Read; rready held from the start until rvalid is seen
	task automatic rchk(input logic [5:0] ad, input logic [31:0] exp);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < 50);
		arvalid <= 0;
		while (!rvalid && n < 50) begin
			@(posedge aclk);
			n++;
		end
		timeout_if(n);
		rd = rdata;
		rs = rresp;
		rready <= 0;
		check(rd, exp);
	endtask

	task automatic clear_all();
		for (int i = 0; i < 6; i++) begin
			wr(regs[i], 32'h0000_0000);
			rchk(regs[i], 32'h0000_0000);
		end
	endtask

	// Every flag register and the enable register come up empty
	task automatic t_reset();
		for (int i = 0; i < 6; i++) rchk(regs[i], 32'h0000_0000);
	endtask

	// All event-pulse sticky sources (no analog pins) with units in capture mode, enables off
	task automatic t_sticky();
		wr(OFS_CAPCMP_MODE, 32'h0000_0000);
		e = '1;
		e.compare = '0;
		periph.fire(e);
		rchk(OFS_FLAGS1, 32'h0000_004F);
		rchk(OFS_FLAGS2, 32'h0000_009B);
		rchk(OFS_FLAGS3, 32'h0000_00CF);
		rchk(OFS_FLAGS4, 32'h0000_0007);
		rchk(OFS_FLAGS5, 32'h0000_0007);
		check({flags.four, flags.three, flags.two, flags.one}, 32'h07CF_9B4F);
		check(flags.five, 32'h0000_0007);
		clear_all();
	endtask

	// Reserved bits stay zero whatever is written
	task automatic t_reserved();
		for (int i = 0; i < 6; i++) wr(regs[i], 32'hFFFF_FFFF);
		rchk(OFS_FLAGS1, 32'h0000_004F);
		rchk(OFS_FLAGS4, 32'h0000_0007);
		rchk(OFS_FLAGS5, 32'h0000_0007);
		rchk(OFS_ENABLES1, 32'h0000_007F);
		clear_all();
	endtask

	// Unit events ignored in PWM, compare matches counted in compare mode
	task automatic t_modes();
		wr(OFS_CAPCMP_MODE, 32'h0000_02AA);
		e = '0;
		e.capture = '1;
		e.compare = '1;
		periph.fire(e);
		rchk(OFS_FLAGS4, 32'h0000_0000);
		rchk(OFS_FLAGS1, 32'h0000_0000);
		wr(OFS_CAPCMP_MODE, 32'h0000_0155);
		rchk(OFS_CAPCMP_MODE, 32'h0000_0155);
		e.capture = '0;
		periph.fire(e);
		rchk(OFS_FLAGS2, 32'h0000_0001);
		rchk(OFS_FLAGS4, 32'h0000_0007);
		clear_all();
	endtask

	// Buffer-state flags follow levels and shrug off writes
	task automatic t_levels();
		periph.set_level('1);
		wr(OFS_FLAGS1, 32'h0000_0000);
		rchk(OFS_FLAGS1, 32'h0000_0030);
		rchk(OFS_FLAGS3, 32'h0000_0030);
		periph.set_level('0);
		rchk(OFS_FLAGS1, 32'h0000_0000);
		rchk(OFS_FLAGS3, 32'h0000_0000);
	endtask

	// Comparator toggles and detector trips in each direction
	task automatic t_analog();
		wr(OFS_CTRL, 32'h0000_0001);
		rchk(OFS_CTRL, 32'h0000_0001);
		periph.set_analog('1);
		repeat (8) @(posedge aclk);
		rchk(OFS_FLAGS2, 32'h0000_0064);
		wr(OFS_FLAGS2, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0000);
		periph.set_analog('0);
		repeat (8) @(posedge aclk);
		rchk(OFS_FLAGS2, 32'h0000_0064);
		wr(OFS_FLAGS2, 32'h0000_0000);
		a = '0;
		a.volt_above = 1;
		periph.set_analog(a);
		repeat (8) @(posedge aclk);
		rchk(OFS_FLAGS2, 32'h0000_0000);
	endtask

	// Request gating by enable, global and peripheral enables
	task automatic t_request();
		wr(OFS_ENABLES1, 32'h0000_0001);
		e = '0;
		e.timer1_ovf = 1;
		periph.fire(e);
		repeat (2) @(posedge aclk);
		check(periph_req, 1'b1);
		check(core_irq, 1'b0);
		check(flags.one, 32'h0000_0001);
		check(enables_one, 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_00C0);
		repeat (2) @(posedge aclk);
		check(core_irq, 1'b1);
		wr(OFS_CTRL, 32'h0000_0080);
		repeat (2) @(posedge aclk);
		check(core_irq, 1'b0);
		wr(OFS_CTRL, 32'h0000_0040);
		repeat (2) @(posedge aclk);
		check(core_irq, 1'b0);
		// Priority mode on: either enable opens the gate
		wr(OFS_CTRL, 32'h0000_0042);
		repeat (2) @(posedge aclk);
		check(core_irq, 1'b1);
		wr(OFS_ENABLES1, 32'h0000_007E);
		repeat (2) @(posedge aclk);
		check(periph_req, 1'b0);
		clear_all();
	endtask

	// Hardware set meets software clear; unmapped places refused
	task automatic t_race_unmapped();
		e = '0;
		e.conv_done = 1;
		wr_ev(OFS_FLAGS1, 32'h0000_0000, e);
		rchk(OFS_FLAGS1, 32'h0000_0040);
		wr(6'h20, 32'hFFFF_FFFF);
		check(ws, RESP_SLVERR);
		rchk(6'h3C, 32'h0000_0000);
		check(rs, RESP_SLVERR);
		// Low lane off: byte registers keep their value, answer still OKAY
		wstrb <= 4'hE;
		awprot <= 3'h7;
		arprot <= 3'h7;
		wr(OFS_ENABLES1, 32'h0000_00FF);
		wstrb <= 4'hF;
		check(ws, RESP_OKAY);
		rchk(OFS_ENABLES1, 32'h0000_0000);
		clear_all();
	endtask

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		t_reset();
		t_sticky();
		t_reserved();
		t_modes();
		t_levels();
		t_analog();
		t_request();
		t_race_unmapped();
		tally_and_finish();
	end
endmodule
